// File: burst_addr_gen.sv
// ****************************************
// read/write burst word order
// ****************************************
module burst_addr_gen
   import mode_reg_pkg::*;
(
   input wire logic [2:0] start_col,
   input wire logic long_burst,
   input wire logic [4:0] beat,
   output logic [4:0] word_col
);
   // low four bits wrap modulo 16 from the 4-aligned start
   always_comb begin
      word_col[3:0] = {start_col[1:0], 2'h0} + beat[3:0];
      word_col[4] = long_burst ? (start_col[2] ^ beat[4]) : 1'b0;
   end
endmodule : burst_addr_gen

// File: burst_strobe_config.sv
module burst_strobe_config
   import mode_reg_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic write_set_point_select,
   input wire logic operating_set_point_select,
   input wire logic mrw_valid,
   input wire logic [5:0] mrw_addr,
   input wire logic [7:0] mrw_data,
   input wire logic mrr_req,
   input wire logic [5:0] mrr_addr,
   output logic mrr_valid,
   output logic [7:0] mrr_data,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [2:0] cmd_col,
   input wire logic cmd_burst_length_select,
   input wire logic cmd_auto_precharge_flag,
   output logic cmd_ready,
   output logic beat_valid,
   output logic [4:0] beat_col,
   output logic [4:0] beat_num,
   output logic beat_last,
   output logic beat_write,
   output logic precharge_start,
   output logic read_postamble,
   output logic wr_preamble_2tck,
   output logic rd_preamble_toggle,
   output logic read_postamble_length
);
   // ****************************************
   // mode register storage
   // ****************************************
   logic [1:0] burst_length_select;
   logic [1:0] sp_wrpre;
   logic [1:0] sp_rdpre;
   logic [2:0] sp_nwr [2];
   logic [1:0] sp_read_postamble_length;
   logic [1:0] next_burst_length_select;
   logic [1:0] next_sp_wrpre;
   logic [1:0] next_sp_rdpre;
   logic [2:0] next_sp_nwr [2];
   logic [1:0] next_sp_read_postamble_length;
   logic next_mrr_valid;
   logic [7:0] next_mrr_data;
   logic reg_hit;
   logic wsp;
   logic osp;
   logic next_wr_preamble_2tck;
   logic next_rd_preamble_toggle;
   logic next_read_postamble_length;

   assign wsp = write_set_point_select;
   assign osp = operating_set_point_select;
   assign reg_hit = mrw_valid && (mrw_addr == BURST_STROBE_ADDR);

   // register writes reach only the write set point copy; burst length has one shared copy
   always_comb begin
      next_burst_length_select = burst_length_select;
      next_sp_wrpre = sp_wrpre;
      next_sp_rdpre = sp_rdpre;
      next_sp_nwr = sp_nwr;
      next_sp_read_postamble_length = sp_read_postamble_length;
      if (reg_hit) begin
         next_burst_length_select = mrw_data[BL_LSB+:2];
         next_sp_wrpre[wsp] = mrw_data[WRPRE_BIT];
         next_sp_rdpre[wsp] = mrw_data[RDPRE_BIT];
         next_sp_nwr[wsp] = mrw_data[NWR_LSB+:3];
         next_sp_read_postamble_length[wsp] = mrw_data[READ_POSTAMBLE_LENGTH_BIT];
      end
      next_mrr_valid = mrr_req && (mrr_addr == BURST_STROBE_ADDR);
      next_mrr_data = 8'h00;
      if (next_mrr_valid) begin
         // write-recovery field reads back as zero
         next_mrr_data[BL_LSB+:2] = burst_length_select;
         next_mrr_data[WRPRE_BIT] = sp_wrpre[wsp];
         next_mrr_data[RDPRE_BIT] = sp_rdpre[wsp];
         next_mrr_data[READ_POSTAMBLE_LENGTH_BIT] = sp_read_postamble_length[wsp];
      end
      next_wr_preamble_2tck = sp_wrpre[osp];
      next_rd_preamble_toggle = sp_rdpre[osp];
      next_read_postamble_length = sp_read_postamble_length[osp];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         burst_length_select <= BL_RST;
         sp_wrpre <= {2{WRPRE_RST}};
         sp_rdpre <= {2{RDPRE_RST}};
         sp_nwr[0] <= NWR_RST;
         sp_nwr[1] <= NWR_RST;
         sp_read_postamble_length <= {2{READ_POSTAMBLE_LENGTH_RST}};
         mrr_valid <= 1'b0;
         mrr_data <= 8'h00;
         wr_preamble_2tck <= WRPRE_RST;
         rd_preamble_toggle <= RDPRE_RST;
         read_postamble_length <= READ_POSTAMBLE_LENGTH_RST;
      end else begin
         burst_length_select <= next_burst_length_select;
         sp_wrpre <= next_sp_wrpre;
         sp_rdpre <= next_sp_rdpre;
         sp_nwr <= next_sp_nwr;
         sp_read_postamble_length <= next_sp_read_postamble_length;
         mrr_valid <= next_mrr_valid;
         mrr_data <= next_mrr_data;
         wr_preamble_2tck <= next_wr_preamble_2tck;
         rd_preamble_toggle <= next_rd_preamble_toggle;
         read_postamble_length <= next_read_postamble_length;
      end
   end

   // ****************************************
   // burst sequencer
   // ****************************************
   burst_state_e state;
   burst_state_e next_state;
   logic [4:0] idx;
   logic [2:0] start_col;
   logic long_burst;
   logic is_write;
   logic ap;
   logic [5:0] cnt;
   logic [4:0] next_idx;
   logic [2:0] next_start_col;
   logic next_long_burst;
   logic next_is_write;
   logic next_ap;
   logic [5:0] next_cnt;
   logic cmd_take;
   logic cmd_long;
   logic last_now;
   logic [4:0] gen_col;
   logic next_cmd_ready;
   logic next_beat_valid;
   logic [4:0] next_beat_col;
   logic [4:0] next_beat_num;
   logic next_beat_last;
   logic next_beat_write;
   logic next_precharge_start;
   logic next_read_postamble;

   burst_addr_gen burst_addr_gen_inst (
      .start_col(start_col),
      .long_burst(long_burst),
      .beat(idx),
      .word_col(gen_col)
   );

   assign cmd_take = cmd_valid && (state == ST_IDLE);
   assign last_now = (state == ST_BURST) && (idx == (long_burst ? LAST_BEAT_32 : LAST_BEAT_16));

   // burst length from field, or from command bit in per-command mode
   always_comb begin
      unique case (burst_length_select)
         BL_CODE_32: cmd_long = 1'b1;
         BL_CODE_OTF: cmd_long = cmd_burst_length_select;
         default: cmd_long = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_start_col = start_col;
      next_long_burst = long_burst;
      next_is_write = is_write;
      next_ap = ap;
      next_cnt = cnt;
      unique case (state)
         ST_IDLE: begin
            if (cmd_take) begin
               next_state = ST_BURST;
               next_idx = 5'h00;
               // writes start aligned; bits 3:2 held zero
               next_start_col = cmd_write ? {cmd_col[2], 2'h0} : cmd_col;
               next_long_burst = cmd_long;
               next_is_write = cmd_write;
               next_ap = cmd_auto_precharge_flag;
            end
         end
         ST_BURST: begin
            next_idx = idx + 5'h01;
            if (last_now) begin
               if (!is_write) begin
                  next_state = ST_POST;
                  next_cnt = read_postamble_length ? POST_LONG_CYC - 6'h01 : POST_SHORT_CYC - 6'h01;
               end else if (ap) begin
                  next_state = ST_RECOVER;
                  next_cnt = nwr_cycles(sp_nwr[osp]) - 6'h01;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_RECOVER, ST_POST: begin
            next_cnt = cnt - 6'h01;
            if (cnt == 6'h00) begin
               next_state = ST_IDLE;
            end
         end
      endcase
      next_cmd_ready = (next_state == ST_IDLE);
      next_beat_valid = (state == ST_BURST);
      next_beat_col = gen_col;
      next_beat_num = idx;
      next_beat_last = last_now;
      next_beat_write = is_write;
      next_precharge_start = (state == ST_RECOVER) && (cnt == 6'h00);
      next_read_postamble = (state == ST_POST);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         idx <= 5'h00;
         start_col <= 3'h0;
         long_burst <= 1'b0;
         is_write <= 1'b0;
         ap <= 1'b0;
         cnt <= 6'h00;
         cmd_ready <= 1'b1;
         beat_valid <= 1'b0;
         beat_col <= 5'h00;
         beat_num <= 5'h00;
         beat_last <= 1'b0;
         beat_write <= 1'b0;
         precharge_start <= 1'b0;
         read_postamble <= 1'b0;
      end else begin
         state <= next_state;
         idx <= next_idx;
         start_col <= next_start_col;
         long_burst <= next_long_burst;
         is_write <= next_is_write;
         ap <= next_ap;
         cnt <= next_cnt;
         cmd_ready <= next_cmd_ready;
         beat_valid <= next_beat_valid;
         beat_col <= next_beat_col;
         beat_num <= next_beat_num;
         beat_last <= next_beat_last;
         beat_write <= next_beat_write;
         precharge_start <= next_precharge_start;
         read_postamble <= next_read_postamble;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   AST_FIRST_ALIGNED: assert property (@(posedge clk) disable iff (!nrst)
      $rose(beat_valid) |-> beat_col[1:0] == 2'h0) else $error("burst start not aligned");
   AST_STEP_WRAP: assert property (@(posedge clk) disable iff (!nrst)
      beat_valid && $past(beat_valid) && !$past(beat_last) && beat_num != HALF_BEAT
      |-> beat_col[3:0] == $past(beat_col[3:0]) + 4'h1) else $error("beat order not modulo 16");
   AST_OTHER_HALF: assert property (@(posedge clk) disable iff (!nrst)
      beat_valid && beat_num == HALF_BEAT
      |-> beat_col[4] != $past(beat_col[4], 16) && beat_col[3:0] == $past(beat_col[3:0], 16))
      else $error("second half offset wrong");
   AST_BL32_LEN: assert property (@(posedge clk) disable iff (!nrst)
      cmd_take && burst_length_select == BL_CODE_32 |-> ##33 (beat_valid && beat_last))
      else $error("32-beat burst length wrong");
   AST_OTF16_LEN: assert property (@(posedge clk) disable iff (!nrst)
      cmd_take && burst_length_select == BL_CODE_OTF && !cmd_burst_length_select
      |-> ##17 (beat_valid && beat_last)) else $error("on-the-fly 16 length wrong");
   AST_NWR_DEFAULT: assert property (@(posedge clk) disable iff (!nrst)
      beat_valid && beat_last && beat_write && ap && sp_nwr[osp] == 3'h0 && $stable(osp)
      |-> ##6 precharge_start) else $error("precharge not after 6 cycles");
   AST_READ_POSTAMBLE_LENGTH_LONG: assert property (@(posedge clk) disable iff (!nrst)
      beat_valid && beat_last && !beat_write && $past(read_postamble_length)
      |=> read_postamble [*2] ##1 !read_postamble) else $error("long postamble not two cycles");
   AST_READ_POSTAMBLE_LENGTH_SHORT: assert property (@(posedge clk) disable iff (!nrst)
      beat_valid && beat_last && !beat_write && !$past(read_postamble_length)
      |=> read_postamble ##1 !read_postamble) else $error("short postamble not one cycle");
   AST_WSP_COPY: assert property (@(posedge clk) disable iff (!nrst)
      reg_hit && !wsp |=> sp_nwr[0] == $past(mrw_data[NWR_LSB+:3]) && sp_nwr[1] == $past(sp_nwr[1]))
      else $error("write reached wrong set point");
   AST_OSP_USE: assert property (@(posedge clk) disable iff (!nrst)
      ##1 rd_preamble_toggle == $past(sp_rdpre[osp])) else $error("active copy not operating set point");
endmodule : burst_strobe_config

// File: burst_strobe_config_bench.sv
module burst_strobe_config_bench
   import mode_reg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, wsp, osp, mrw_valid, mrr_req, mrr_valid, cmd_valid, cmd_write, cmd_bls, cmd_ap, cmd_ready;
   logic [5:0] mrw_addr, mrr_addr;
   logic [7:0] mrw_data, mrr_data;
   logic [2:0] cmd_col;
   logic [4:0] beat_col, beat_num;
   logic beat_valid, beat_last, beat_write, precharge_start, read_postamble, wr_pre, rd_tog, post_len;
   int err_count = 0;
   int tests_run = 0;
   logic [1:0] bl;
   int nwr_tab [8] = '{6, 10, 16, 20, 24, 30, 34, 40};

   // ****************************************
   // clock, design and controller
   // ****************************************
   initial clk = 1'b0;
   always #4 clk = ~clk;

   burst_strobe_config burst_strobe_config_inst (.clk(clk), .nrst(nrst), .write_set_point_select(wsp),
      .operating_set_point_select(osp), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr), .mrw_data(mrw_data),
      .mrr_req(mrr_req), .mrr_addr(mrr_addr), .mrr_valid(mrr_valid), .mrr_data(mrr_data),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_col(cmd_col), .cmd_burst_length_select(cmd_bls),
      .cmd_auto_precharge_flag(cmd_ap), .cmd_ready(cmd_ready), .beat_valid(beat_valid), .beat_col(beat_col),
      .beat_num(beat_num), .beat_last(beat_last), .beat_write(beat_write), .precharge_start(precharge_start),
      .read_postamble(read_postamble), .wr_preamble_2tck(wr_pre), .rd_preamble_toggle(rd_tog),
      .read_postamble_length(post_len));

   controller_model controller_model_inst (.clk(clk), .cmd_ready(cmd_ready), .write_set_point_select(wsp),
      .operating_set_point_select(osp), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr), .mrw_data(mrw_data),
      .mrr_req(mrr_req), .mrr_addr(mrr_addr), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_col(cmd_col), .cmd_burst_length_select(cmd_bls), .cmd_auto_precharge_flag(cmd_ap));

   // ****************************************
   // compare, register read and burst tasks
   // ****************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // answer stands for the one cycle after the request edge
   task automatic rd(input logic [5:0] a, input logic v, input logic [7:0] e);
      controller_model_inst.mrr(a);
      check("mrr_valid", 8'(mrr_valid), 8'(v));
      check("mrr_data", mrr_data, e);
   endtask : rd

   // one command; beats, postamble cycles or precharge delay (npost) checked
   task automatic burst(input logic w, input logic [2:0] c, input logic b, input logic ap, input int npost);
      logic longb;
      logic [4:0] ec;
      int k;
      longb = (bl == BL_CODE_32) || (bl == BL_CODE_OTF && b);
      controller_model_inst.cmd(w, c, b, ap);
      k = 1; // take edge already passed
      while (beat_valid !== 1'b1 && k < 8) begin
         @(negedge clk);
         k++;
      end
      check("latency", 8'(k), 8'h02);
      for (int i = 0; i < (longb ? 32 : 16); i++) begin
         ec[3:0] = (w ? 4'h0 : {c[1:0], 2'h0}) + 4'(i);
         ec[4] = longb & (c[2] ^ i[4]);
         check("beat_col", 8'(beat_col), 8'(ec));
         check("beat_last", 8'(beat_last), 8'(i == (longb ? 31 : 15)));
         check("beat_write", 8'(beat_write), 8'(w));
         check("beat_num", 8'(beat_num), 8'(i));
         @(negedge clk);
      end
      k = 0;
      while (read_postamble === 1'b1 && k < 8) begin
         @(negedge clk);
         k++;
      end
      if (!w) check("postamble", 8'(k), 8'(npost));
      if (ap) begin
         k = 1;
         while (precharge_start !== 1'b1 && k < 60) begin
            @(negedge clk);
            k++;
         end
         check("precharge", 8'(k), 8'(npost));
      end
   endtask : burst

   task automatic report_and_stop();
      if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      bl = BL_CODE_16;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      check("reset outs", {4'h0, cmd_ready, wr_pre, rd_tog, post_len}, 8'h0C);
      rd(6'h01, 1'b1, 8'h04);
      rd(6'h02, 1'b0, 8'h00);
      burst(1'b0, 3'h1, 1'b0, 1'b0, 1);
      for (int code = 0; code < 8; code++) begin
         controller_model_inst.mrw(6'h01, {1'b0, 3'(code), 4'h4});
         burst(1'b1, 3'h4, 1'b0, 1'b1, nwr_tab[code]);
      end
      rd(6'h01, 1'b1, 8'h04);
      controller_model_inst.mrw(6'h01, 8'h8D);
      bl = BL_CODE_32;
      repeat (2) @(negedge clk);
      check("active fields", {5'h00, wr_pre, rd_tog, post_len}, 8'h07);
      burst(1'b0, 3'h5, 1'b0, 1'b0, 2);
      controller_model_inst.mrw(6'h01, 8'h06);
      bl = BL_CODE_OTF;
      burst(1'b0, 3'h3, 1'b1, 1'b0, 1);
      burst(1'b0, 3'h7, 1'b0, 1'b0, 1);
      controller_model_inst.set_points(1'b1, 1'b0);
      controller_model_inst.mrw(6'h01, 8'h8E);
      rd(6'h01, 1'b1, 8'h8E);
      check("inactive write", {6'h00, rd_tog, post_len}, 8'h00);
      controller_model_inst.set_points(1'b0, 1'b0);
      rd(6'h01, 1'b1, 8'h06);
      check("inactive ignored", {6'h00, rd_tog, post_len}, 8'h00);
      controller_model_inst.set_points(1'b0, 1'b1);
      repeat (2) @(negedge clk);
      check("operating copy", {6'h00, rd_tog, post_len}, 8'h03);
      burst(1'b0, 3'h0, 1'b0, 1'b0, 2);
      report_and_stop();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
endmodule : burst_strobe_config_bench

// File: controller_model.sv
// ****************************************
// controller side of the command bus
// ****************************************
module controller_model
   import mode_reg_pkg::*;
(
   input wire logic clk,
   input wire logic cmd_ready,
   output logic write_set_point_select,
   output logic operating_set_point_select,
   output logic mrw_valid,
   output logic [5:0] mrw_addr,
   output logic [7:0] mrw_data,
   output logic mrr_req,
   output logic [5:0] mrr_addr,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [2:0] cmd_col,
   output logic cmd_burst_length_select,
   output logic cmd_auto_precharge_flag
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle levels at time zero
   initial begin
      {write_set_point_select, operating_set_point_select, mrw_valid, mrr_req, cmd_valid} = 5'h00;
      {mrw_addr, mrw_data, mrr_addr} = 20'h00000;
      {cmd_write, cmd_col, cmd_burst_length_select, cmd_auto_precharge_flag} = 6'h00;
   end

   // set-point selects from the control register
   task automatic set_points(input logic w, input logic o);
      @(negedge clk);
      write_set_point_select = w;
      operating_set_point_select = o;
   endtask : set_points

   // register write; callers never pass reserved codes
   task automatic mrw(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      mrw_valid = 1'b1;
      mrw_addr = a;
      mrw_data = d;
      @(negedge clk);
      mrw_valid = 1'b0;
      mrw_data = ~d;
   endtask : mrw

   // register read request, one cycle
   task automatic mrr(input logic [5:0] a);
      @(negedge clk);
      mrr_req = 1'b1;
      mrr_addr = a;
      @(negedge clk);
      mrr_req = 1'b0;
      mrr_addr = ~a;
   endtask : mrr

   // command held until taken while ready; writes keep bits 3:2 low
   task automatic cmd(input logic w, input logic [2:0] c, input logic b, input logic ap);
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_col = w ? {c[2], 2'h0} : c;
      cmd_burst_length_select = b;
      cmd_auto_precharge_flag = ap;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_col = ~cmd_col;
      cmd_burst_length_select = ~b;
   endtask : cmd
endmodule : controller_model

// File: mode_reg_pkg.sv
package mode_reg_pkg;
   // ****************************************
   // register address and field layout
   // ****************************************
   localparam logic [5:0] BURST_STROBE_ADDR = 6'h01;
   localparam int BL_LSB = 0;
   localparam int WRPRE_BIT = 2;
   localparam int RDPRE_BIT = 3;
   localparam int NWR_LSB = 4;
   localparam int READ_POSTAMBLE_LENGTH_BIT = 7;

   // ****************************************
   // burst length encodings
   // ****************************************
   localparam logic [1:0] BL_CODE_16 = 2'h0;
   localparam logic [1:0] BL_CODE_32 = 2'h1;
   localparam logic [1:0] BL_CODE_OTF = 2'h2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [1:0] BL_RST = 2'h0;
   localparam logic WRPRE_RST = 1'b1;
   localparam logic RDPRE_RST = 1'b0;
   localparam logic [2:0] NWR_RST = 3'h0;
   localparam logic READ_POSTAMBLE_LENGTH_RST = 1'b0;

   // ****************************************
   // burst and postamble counts
   // ****************************************
   localparam logic [4:0] LAST_BEAT_16 = 5'h0F;
   localparam logic [4:0] LAST_BEAT_32 = 5'h1F;
   localparam logic [4:0] HALF_BEAT = 5'h10;
   localparam logic [5:0] POST_SHORT_CYC = 6'h01;
   localparam logic [5:0] POST_LONG_CYC = 6'h02;

   typedef enum {ST_IDLE, ST_BURST, ST_RECOVER, ST_POST} burst_state_e;

   // write-recovery code to clock cycles
   function automatic logic [5:0] nwr_cycles(input logic [2:0] code);
      logic [5:0] cyc;
      cyc = 6'h06;
      unique case (code)
         3'h0: cyc = 6'h06;
         3'h1: cyc = 6'h0A;
         3'h2: cyc = 6'h10;
         3'h3: cyc = 6'h14;
         3'h4: cyc = 6'h18;
         3'h5: cyc = 6'h1E;
         3'h6: cyc = 6'h22;
         3'h7: cyc = 6'h28;
      endcase
      return cyc;
   endfunction : nwr_cycles
endpackage : mode_reg_pkg
